// ---- logic/sdt_cfg.svh ----
`ifndef SDT_CFG_SVH
`define SDT_CFG_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define SDT_OFF_CTRL   8'h00
`define SDT_OFF_PS     8'h04
`define SDT_OFF_SEGEN  8'h08
`define SDT_OFF_STAT   8'h0C
`define SDT_OFF_MASK   8'h10
`define SDT_OFF_TSTAT  8'h14
`define SDT_PIX_PAGE   2'h1

// ---------------------------------------------------------------
// Field masks and reset values
// ---------------------------------------------------------------
`define SDT_CTRL_WMASK 8'hDF
`define SDT_PS_WMASK   8'h0F
`define SDT_SEGEN_RST  8'hFF
`define SDT_BIT_FRAME  0

// ---------------------------------------------------------------
// Timing counts
// ---------------------------------------------------------------
`define SDT_SYS_DIV_LAST 8'hFF
`define SDT_UNITS_STATIC 7'h7F
`define SDT_UNITS_TWO    7'h3F
`define SDT_UNITS_MANY   7'h1F

// ---------------------------------------------------------------
// Bus answers
// ---------------------------------------------------------------
`define SDT_RESP_OKAY   2'h0
`define SDT_RESP_SLVERR 2'h2

`endif

// ---- logic/sdt_display_ctrl.sv ----
`include "sdt_cfg.svh"

// Overview of operation
// - Drive up to 32 segments, four commons.
// - Configure via control, segment enable, prescale.
// - Sixteen pixel bytes, one bit per pixel.
// - Control bit 7 enables drive, resets 0.
// - Control bit 6 stops display in sleep.
// - Control bit 5 always reads zero.
// - Control bit 4 powers bias generator.
// - Bits 3:2 choose sys/256, timer, RC.
// - Bits 1:0 choose commons and segment count.
// - Prescale bits 3:0 hold frame prescale.
// - Prescale bits 7:4 read zero.
// - Frame is 128 or 96 times prescale+1.
// - Frame starts common zero; flag after fetch.
// - System divider fixed at 256.
module sdt_display_ctrl (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // Write address channel
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    // Write data channel
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    // Write response channel
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    // Read address channel
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    // Read data channel
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    // System and clock source inputs
    input  wire logic        sleep_i,
    input  wire logic        timer_one_clock_input_i,
    input  wire logic        rc_osc_i,
    // Panel drive
    output logic [3:0]       common_o,
    output logic [31:0]      segment_o,
    output logic             bias_generator_enable_o,
    // Interrupt
    output logic             irq_o
);

    sdt_pkg::sdt_core_s st;
    sdt_pkg::sdt_core_s nx;
    logic               run;
    logic               tm_step;
    logic [1:0]         tm_com;
    logic               wr_go;
    logic               frm_ev;
    logic               stat_clr;
    logic [31:0]        row;
    logic [31:0]        pin_mask;
    logic [31:0]        seg_mask;
    logic [7:0]         ar_q;

    // ---------------------------------------------------------------
    // Segment pin enables and common pin takeover
    // ---------------------------------------------------------------
    // Each enable bit covers a fixed group of segment pins.
    localparam logic [4:0] GRP_LO [8] = '{5'd0, 5'd5, 5'd9, 5'd12,
                                          5'd16, 5'd20, 5'd27, 5'd29};

    for (genvar g = 0; g < 32; g++) begin : g_pin
        always_comb begin
            pin_mask[g] = 1'b0;
            for (int k = 0; k < 8; k++) begin
                if (5'(g) >= GRP_LO[k]) begin
                    pin_mask[g] = st.seg_en[k];
                end
            end
        end
    end

    // Multiplexed modes take the top segment pins as commons.
    assign seg_mask = pin_mask & (32'hFFFF_FFFF >> st.ctrl.common_count_select);

    // Drive stops when disabled, or in sleep when asked to.
    assign run = st.ctrl.drive_enable_bit && !(sleep_i && st.ctrl.sleep_stop_bit);

    // ---------------------------------------------------------------
    // Frame timer
    // ---------------------------------------------------------------
    sdt_frame_timer u_timer (
        .clk_i                   (clk_i),
        .reset_n_i               (reset_n_i),
        .run_i                   (run),
        .clk_src_i               (st.ctrl.clock_source_select),
        .com_sel_i               (st.ctrl.common_count_select),
        .prescale_i              (st.ps),
        .timer_one_clock_input_i (timer_one_clock_input_i),
        .rc_osc_i                (rc_osc_i),
        .step_o                  (tm_step),
        .com_idx_o               (tm_com)
    );

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        nx       = st;
        stat_clr = 1'b0;
        wr_go    = st.aw_held && st.w_held && !st.bvalid;
        row      = {st.pix[{tm_com, 2'h3}], st.pix[{tm_com, 2'h2}],
                    st.pix[{tm_com, 2'h1}], st.pix[{tm_com, 2'h0}]};
        // The last common row fetched ends the frame's data access.
        frm_ev   = run && tm_step && (tm_com == st.ctrl.common_count_select);

        // Write address and data are taken independently.
        if (s_axi_awvalid_i && st.awready) begin
            nx.aw_held = 1'b1;
            nx.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && st.wready) begin
            nx.w_held = 1'b1;
            nx.wdata  = s_axi_wdata_i[7:0];
            nx.wstrb0 = s_axi_wstrb_i[0];
        end
        if (st.bvalid && s_axi_bready_i) begin
            nx.bvalid = 1'b0;
        end
        if (wr_go) begin
            nx.aw_held = 1'b0;
            nx.w_held  = 1'b0;
            nx.bvalid  = 1'b1;
            nx.bresp   = `SDT_RESP_OKAY;
            if (st.aw_addr == `SDT_OFF_CTRL) begin
                if (st.wstrb0) begin
                    nx.ctrl = sdt_pkg::sdt_ctrl_s'(st.wdata & `SDT_CTRL_WMASK);
                end
            end else if (st.aw_addr == `SDT_OFF_PS) begin
                if (st.wstrb0) begin
                    nx.ps = st.wdata[3:0];
                end
            end else if (st.aw_addr == `SDT_OFF_SEGEN) begin
                if (st.wstrb0) begin
                    nx.seg_en = st.wdata;
                end
            end else if (st.aw_addr == `SDT_OFF_STAT) begin
                stat_clr = st.wstrb0 && st.wdata[`SDT_BIT_FRAME];
            end else if (st.aw_addr == `SDT_OFF_MASK) begin
                if (st.wstrb0) begin
                    nx.mask = st.wdata[`SDT_BIT_FRAME];
                end
            end else if (st.aw_addr == `SDT_OFF_TSTAT) begin
                nx.bresp = `SDT_RESP_OKAY;
            end else if (st.aw_addr[7:6] == `SDT_PIX_PAGE && st.aw_addr[1:0] == 2'h0) begin
                if (st.wstrb0) begin
                    nx.pix[st.aw_addr[5:2]] = st.wdata;
                end
            end else begin
                nx.bresp = `SDT_RESP_SLVERR;
            end
        end
        nx.awready = !nx.aw_held && !nx.bvalid;
        nx.wready  = !nx.w_held && !nx.bvalid;

        // Reads answer one cycle after the address is taken.
        if (st.rvalid && s_axi_rready_i) begin
            nx.rvalid = 1'b0;
        end
        if (s_axi_arvalid_i && st.arready) begin
            nx.rvalid = 1'b1;
            nx.rresp  = `SDT_RESP_OKAY;
            nx.rdata  = 8'h00;
            if (s_axi_araddr_i == `SDT_OFF_CTRL) begin
                nx.rdata = st.ctrl & `SDT_CTRL_WMASK;
            end else if (s_axi_araddr_i == `SDT_OFF_PS) begin
                nx.rdata = {4'h0, st.ps};
            end else if (s_axi_araddr_i == `SDT_OFF_SEGEN) begin
                nx.rdata = st.seg_en;
            end else if (s_axi_araddr_i == `SDT_OFF_STAT) begin
                nx.rdata = {7'h00, st.stat};
            end else if (s_axi_araddr_i == `SDT_OFF_MASK) begin
                nx.rdata = {7'h00, st.mask};
            end else if (s_axi_araddr_i == `SDT_OFF_TSTAT) begin
                nx.rdata = {5'h00, run, tm_com};
            end else if (s_axi_araddr_i[7:6] == `SDT_PIX_PAGE
                         && s_axi_araddr_i[1:0] == 2'h0) begin
                nx.rdata = st.pix[s_axi_araddr_i[5:2]];
            end else begin
                nx.rresp = `SDT_RESP_SLVERR;
            end
        end
        nx.arready = !nx.rvalid;

        // A frame event in the clearing cycle keeps the flag set.
        nx.stat = (st.stat && !stat_clr) || frm_ev;
        nx.irq  = nx.stat && nx.mask;

        // Scan: fetch the row of the new common at each phase step.
        if (!run) begin
            nx.com = 4'h0;
            nx.seg = 32'h0000_0000;
        end else if (tm_step) begin
            nx.com = 4'h1 << tm_com;
            nx.seg = row & seg_mask;
        end
        nx.bias = st.ctrl.bias_generator_enable;
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            st        <= '0;
            st.seg_en <= `SDT_SEGEN_RST;
        end else begin
            st <= nx;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign s_axi_awready_o         = st.awready;
    assign s_axi_wready_o          = st.wready;
    assign s_axi_bresp_o           = st.bresp;
    assign s_axi_bvalid_o          = st.bvalid;
    assign s_axi_arready_o         = st.arready;
    assign s_axi_rdata_o           = {24'h00_0000, st.rdata};
    assign s_axi_rresp_o           = st.rresp;
    assign s_axi_rvalid_o          = st.rvalid;
    assign common_o                = st.com;
    assign segment_o               = st.seg;
    assign bias_generator_enable_o = st.bias;
    assign irq_o                   = st.irq;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            ar_q <= s_axi_araddr_i;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    chk_enable_reset: assert property ($rose(reset_n_i) |-> !st.ctrl.drive_enable_bit)
        else $error("drive enable not cleared by reset");
    chk_ctrl_rsvd: assert property (s_axi_rvalid_o && ar_q == 8'h00
        |-> s_axi_rdata_o[5] == 1'b0)
        else $error("control bit 5 read back as one");
    chk_ps_rsvd: assert property (s_axi_rvalid_o && ar_q == 8'h04
        |-> s_axi_rdata_o[7:4] == 4'h0)
        else $error("prescale upper bits read back nonzero");
    chk_disable_quiet: assert property (!st.ctrl.drive_enable_bit
        |=> common_o == 4'h0 && segment_o == 32'h0000_0000)
        else $error("panel driven while disabled");
    chk_no_frame_off: assert property (!st.ctrl.drive_enable_bit ##1 !st.ctrl.drive_enable_bit
        |-> !frm_ev)
        else $error("frame event while disabled");
    chk_sleep_stop: assert property (sleep_i && st.ctrl.sleep_stop_bit
        |=> common_o == 4'h0)
        else $error("display ran in sleep with stop set");
    chk_com_onehot: assert property ($onehot0(common_o))
        else $error("more than one common active");
    chk_frame_start: assert property ($rose(common_o[0])
        |-> $past(tm_step) && $past(tm_com) == 2'h0)
        else $error("common zero rose outside a frame start");
    chk_frame_flag: assert property (frm_ev |=> st.stat ##1 (irq_o == st.mask))
        else $error("frame flag or interrupt not raised");
    chk_seg_four: assert property (tm_step && run && st.ctrl.common_count_select == 2'h3
        |=> segment_o[31:29] == 3'h0)
        else $error("common pins driven as segments");
    chk_bias_write: assert property (wr_go && st.aw_addr == 8'h00 && st.wstrb0
        |=> ##1 bias_generator_enable_o == $past(st.ctrl.bias_generator_enable))
        else $error("bias enable did not follow control write");
    chk_write_resp: assert property (wr_go |=> s_axi_bvalid_o && !s_axi_awready_o)
        else $error("write not answered");
    chk_read_resp: assert property (s_axi_arvalid_i && s_axi_arready_o
        |=> s_axi_rvalid_o)
        else $error("read not answered next cycle");

endmodule

// ---- logic/sdt_frame_timer.sv ----
`include "sdt_cfg.svh"

module sdt_frame_timer (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    // Configuration
    input  wire logic       run_i,
    input  wire logic [1:0] clk_src_i,
    input  wire logic [1:0] com_sel_i,
    input  wire logic [3:0] prescale_i,
    // Clock source pins
    input  wire logic       timer_one_clock_input_i,
    input  wire logic       rc_osc_i,
    // Phase events
    output logic            step_o,
    output logic [1:0]      com_idx_o
);

    sdt_pkg::sdt_tmr_s st;
    sdt_pkg::sdt_tmr_s nx;
    logic              tick;
    logic [6:0]        units_last;

    // ---------------------------------------------------------------
    // Source tick and phase counting
    // ---------------------------------------------------------------
    always_comb begin
        nx = st;
        nx.t1_sync = {st.t1_sync[1:0], timer_one_clock_input_i};
        nx.rc_sync = {st.rc_sync[1:0], rc_osc_i};
        nx.step    = 1'b0;
        nx.run_q   = run_i;
        if (clk_src_i == 2'h0) begin
            tick = (st.sys_div == `SDT_SYS_DIV_LAST);
        end else if (clk_src_i == 2'h1) begin
            tick = st.t1_sync[1] && !st.t1_sync[2];
        end else begin
            tick = st.rc_sync[1] && !st.rc_sync[2];
        end
        case (com_sel_i)
            2'h0:    units_last = `SDT_UNITS_STATIC;
            2'h1:    units_last = `SDT_UNITS_TWO;
            default: units_last = `SDT_UNITS_MANY;
        endcase
        if (!run_i) begin
            nx.sys_div = 8'h00;
            nx.pre     = 4'h0;
            nx.unit    = 7'h00;
            nx.com     = 2'h0;
        end else begin
            nx.sys_div = st.sys_div + 8'h01;
            if (!st.run_q) begin
                nx.step = 1'b1;
            end else if (tick) begin
                if (st.pre == prescale_i) begin
                    nx.pre = 4'h0;
                    if (st.unit >= units_last) begin
                        nx.unit = 7'h00;
                        nx.step = 1'b1;
                        nx.com  = (st.com >= com_sel_i) ? 2'h0 : st.com + 2'h1;
                    end else begin
                        nx.unit = st.unit + 7'h01;
                    end
                end else begin
                    nx.pre = st.pre + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    assign step_o    = st.step;
    assign com_idx_o = st.com;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    chk_idle_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        run_i && st.run_q && !tick |=> $stable(st.pre) && $stable(st.unit))
        else $error("frame counters moved without a source tick");
    chk_sys_div: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        run_i && clk_src_i == 2'h0 && tick |-> st.sys_div == 8'hFF)
        else $error("system tick not at divide by 256");
    chk_com_range: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $stable(com_sel_i) && step_o |-> com_idx_o <= com_sel_i)
        else $error("common index beyond selected count");

endmodule

// ---- logic/sdt_pkg.sv ----
package sdt_pkg;

    // Display control register layout.
    typedef struct packed {
        logic       drive_enable_bit;
        logic       sleep_stop_bit;
        logic       rsvd;
        logic       bias_generator_enable;
        logic [1:0] clock_source_select;
        logic [1:0] common_count_select;
    } sdt_ctrl_s;

    // Frame timer state.
    typedef struct packed {
        logic [2:0] t1_sync;
        logic [2:0] rc_sync;
        logic [7:0] sys_div;
        logic [3:0] pre;
        logic [6:0] unit;
        logic [1:0] com;
        logic       step;
        logic       run_q;
    } sdt_tmr_s;

    // Core state: registers, scan outputs and bus slave.
    typedef struct packed {
        sdt_ctrl_s       ctrl;
        logic [3:0]      ps;
        logic [7:0]      seg_en;
        logic [15:0][7:0] pix;
        logic            stat;
        logic            mask;
        logic            irq;
        logic [3:0]      com;
        logic [31:0]     seg;
        logic            bias;
        logic            awready;
        logic            wready;
        logic            aw_held;
        logic [7:0]      aw_addr;
        logic            w_held;
        logic [7:0]      wdata;
        logic            wstrb0;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            arready;
        logic            rvalid;
        logic [7:0]      rdata;
        logic [1:0]      rresp;
    } sdt_core_s;

endpackage

// ---- verification/sdt_panel_model.sv ----
module sdt_panel_model (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    // Panel lines
    input  wire logic [3:0]       common_i,
    input  wire logic [31:0]      segment_i,
    // Observations
    output logic      [3:0][31:0] rows_o,
    output logic      [7:0]       bad_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------------------------
    // Glass behaviour
    // ---------------------------------------------------------------
    // The glass latches the row on its active common; two commons at once would short the panel.
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            bad_o <= 8'h00;
        end else begin
            if (common_i != 4'h0 && !$onehot(common_i)) begin
                bad_o <= bad_o + 8'h01;
            end
            for (int c = 0; c < 4; c++) begin
                if (common_i[c]) begin
                    rows_o[c] <= segment_i;
                end
            end
        end
    end
endmodule

// ---- verification/tb_segment_display_timing_control.sv ----
`include "sdt_cfg.svh"

module tb_segment_display_timing_control;
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    logic             clk_i = 1'b0;
    logic             rst_n = 1'b0;
    logic [7:0]       awaddr = 8'h00;
    logic             awvalid = 1'b0;
    logic [31:0]      wdata = 32'h0000_0000;
    logic             wvalid = 1'b0;
    logic             bready = 1'b0;
    logic [7:0]       araddr = 8'h00;
    logic             arvalid = 1'b0;
    logic             rready = 1'b0;
    logic             sleep = 1'b0;
    logic             t1_pin = 1'b0;
    logic             rc_pin = 1'b0;
    logic             awready, wready, bvalid, arready, rvalid, bias, irq;
    logic [1:0]       bresp, rresp;
    logic [31:0]      rdata, seg;
    logic [3:0]       com;
    logic [3:0][31:0] rows;
    logic [7:0]       bad;
    logic [7:0]       pv [16];
    int               fail_count = 0;
    int               checks_done = 0;
    int               cyc = 0;
    int               t1_cnt = 0;
    int               rc_cnt = 0;

    // ---------------------------------------------------------------
    // Clock, source pins and timeout
    // ---------------------------------------------------------------
    always #2 clk_i = ~clk_i;

    // Timer pin period is 8 clocks and RC pin period 6, so the frame length names the source.
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        t1_cnt <= (t1_cnt == 3) ? 0 : t1_cnt + 1;
        rc_cnt <= (rc_cnt == 2) ? 0 : rc_cnt + 1;
        if (t1_cnt == 3) t1_pin <= ~t1_pin;
        if (rc_cnt == 2) rc_pin <= ~rc_pin;
        if (cyc == 98000) begin
            fail_count = fail_count + 1;
            results();
        end
    end

    sdt_display_ctrl dut (
        .clk_i(clk_i), .reset_n_i(rst_n),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .sleep_i(sleep),
        .timer_one_clock_input_i(t1_pin), .rc_osc_i(rc_pin), .common_o(com),
        .segment_o(seg), .bias_generator_enable_o(bias), .irq_o(irq)
    );

    sdt_panel_model panel (
        .clk_i(clk_i), .reset_n_i(rst_n), .common_i(com), .segment_i(seg),
        .rows_o(rows), .bad_o(bad)
    );

    // ---------------------------------------------------------------
    // Bus and check tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_done;
        logic w_done;
        @(posedge clk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_done = 1'b0;
        w_done = 1'b0;
        while (!(aw_done && w_done)) begin
            @(posedge clk_i);
            aw_done |= awready;
            w_done |= wready;
            awvalid <= awvalid & ~awready;
            wvalid <= wvalid & ~wready;
        end
        while (bvalid !== 1'b1) @(posedge clk_i);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_i);
            arvalid <= arvalid & ~arready;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic put(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk({30'h0000_0000, r}, {30'h0000_0000, `SDT_RESP_OKAY});
    endtask

    task automatic get(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(d, exp);
        chk({30'h0000_0000, r}, {30'h0000_0000, `SDT_RESP_OKAY});
    endtask

    task automatic wait_irq();
        while (irq !== 1'b0) @(posedge clk_i);
        while (irq !== 1'b1) @(posedge clk_i);
    endtask

    // Pixel row of common c with the top m segments given to commons and pins 4:0 disabled.
    function automatic logic [31:0] row(input int c, input int m);
        logic [31:0] v;
        v = {pv[4*c+3], pv[4*c+2], pv[4*c+1], pv[4*c]};
        return v & (32'hFFFF_FFFF >> m) & 32'hFFFF_FFE0;
    endfunction

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0]  r;
        get(`SDT_OFF_CTRL, 32'h0000_0000);
        get(`SDT_OFF_PS, 32'h0000_0000);
        get(`SDT_OFF_SEGEN, 32'h0000_00FF);
        get(`SDT_OFF_STAT, 32'h0000_0000);
        get(`SDT_OFF_MASK, 32'h0000_0000);
        chk({31'h0000_0000, bias}, 32'h0000_0000);
        put(`SDT_OFF_CTRL, 32'h0000_003F);
        get(`SDT_OFF_CTRL, 32'h0000_001F);
        chk({31'h0000_0000, bias}, 32'h0000_0001);
        put(`SDT_OFF_CTRL, 32'h0000_002F);
        @(posedge clk_i);
        chk({31'h0000_0000, bias}, 32'h0000_0000);
        get(`SDT_OFF_CTRL, 32'h0000_000F);
        put(`SDT_OFF_PS, 32'h0000_00FF);
        get(`SDT_OFF_PS, 32'h0000_000F);
        for (int i = 0; i < 16; i++) begin
            pv[i] = 8'h37 + 8'(i) * 8'h1D;
            put(8'h40 + 8'(4 * i), {24'h00_0000, pv[i]});
        end
        for (int i = 0; i < 16; i++) get(8'h40 + 8'(4 * i), {24'h00_0000, pv[i]});
        chk({28'h000_0000, com}, 32'h0000_0000);
        get(`SDT_OFF_TSTAT, 32'h0000_0000);
        wr(8'h3C, 32'h0000_005A, r);
        chk({30'h0000_0000, r}, {30'h0000_0000, `SDT_RESP_SLVERR});
        rd(8'h3C, d, r);
        chk({30'h0000_0000, r}, {30'h0000_0000, `SDT_RESP_SLVERR});
        put(`SDT_OFF_SEGEN, 32'h0000_00FE);
        put(`SDT_OFF_MASK, 32'h0000_0001);
    endtask

    task automatic run(input logic [1:0] cs, input logic [1:0] m, input logic [3:0] ps,
                       input int per);
        int t0;
        int n;
        n = int'(m) + 1;
        put(`SDT_OFF_PS, {28'h000_0000, ps});
        put(`SDT_OFF_CTRL, {24'h00_0000, 4'b1000, cs, m});
        wait_irq();
        chk({28'h000_0000, com}, 32'h0000_0001 << (n - 1));
        chk(seg, row(n - 1, int'(m)));
        put(`SDT_OFF_STAT, 32'h0000_0001);
        // The first frame after enable is cut short, so a later one is timed.
        wait_irq();
        t0 = cyc;
        put(`SDT_OFF_STAT, 32'h0000_0001);
        wait_irq();
        chk(32'(cyc - t0), 32'((m == 2'b10 ? 96 : 128) * (int'(ps) + 1) * per));
        for (int c = 0; c < n; c++) chk(rows[c], row(c, int'(m)));
        put(`SDT_OFF_CTRL, 32'h0000_0000);
        put(`SDT_OFF_STAT, 32'h0000_0001);
        chk({28'h000_0000, com}, 32'h0000_0000);
        chk(seg, 32'h0000_0000);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
    endtask

    task automatic t_sleep();
        @(posedge clk_i);
        sleep <= 1'b1;
        put(`SDT_OFF_PS, 32'h0000_0000);
        put(`SDT_OFF_CTRL, 32'h0000_0087);
        wait_irq();
        chk({28'h000_0000, com}, 32'h0000_0008);
        put(`SDT_OFF_CTRL, 32'h0000_00C7);
        put(`SDT_OFF_STAT, 32'h0000_0001);
        chk({28'h000_0000, com}, 32'h0000_0000);
        repeat (1500) @(posedge clk_i);
        get(`SDT_OFF_STAT, 32'h0000_0000);
        put(`SDT_OFF_MASK, 32'h0000_0000);
        sleep <= 1'b0;
        repeat (1500) @(posedge clk_i);
        get(`SDT_OFF_STAT, 32'h0000_0001);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        chk({24'h00_0000, bad}, 32'h0000_0000);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        rst_n <= 1'b1;
        @(posedge clk_i);
        t_regs();
        run(2'b01, 2'b00, 4'h0, 8);
        run(2'b01, 2'b01, 4'h1, 8);
        run(2'b01, 2'b11, 4'h0, 8);
        run(2'b10, 2'b10, 4'h1, 6);
        run(2'b11, 2'b11, 4'h0, 6);
        run(2'b00, 2'b10, 4'h0, 256);
        t_sleep();
        results();
    end
endmodule
